// ==== hdl/lsq_consts.svh ====
// Offsets, fields, reset values and timing counts of the list sequencer
`ifndef LSQ_CONSTS_SVH
`define LSQ_CONSTS_SVH
`define LSQ_CLK_NS        100
`define LSQ_TICK_NS       1000000
`define LSQ_MS_CYCLES     (`LSQ_TICK_NS / `LSQ_CLK_NS)
`define LSQ_MAX_STEPS     7'd100
`define LSQ_COUNT_MIN     14'd1
`define LSQ_COUNT_MAX     14'd9999
`define LSQ_ENDLESS_CODE  32'h7E94F484
`define LSQ_DWELL_MIN     22'd10
`define LSQ_DWELL_MAX     22'd3600000
`define LSQ_SET_MAX       22'h00C350
`define LSQ_L_CURR        3'd0
`define LSQ_L_VOLT        3'd1
`define LSQ_L_DWELL       3'd2
`define LSQ_L_START       3'd3
`define LSQ_L_END         3'd4
`define LSQ_A_CTRL        8'h00
`define LSQ_A_CONFIG      8'h04
`define LSQ_A_COUNT       8'h08
`define LSQ_A_IMM_CURR    8'h0C
`define LSQ_A_IMM_VOLT    8'h10
`define LSQ_A_STATUS      8'h14
`define LSQ_A_LIST_BASE   8'h18
`define LSQ_A_LIST_LAST   8'h3C
`define LSQ_CTRL_ARM      0
`define LSQ_CTRL_ABORT    1
`define LSQ_CTRL_TRIG     2
`define LSQ_CFG_PACED     0
`define LSQ_CFG_KEEP      1
`define LSQ_CFG_CONT      2
`define LSQ_COUNT_ENDLESS 31
`endif

// ==== hdl/lsq_pkg.sv ====
// Types of the list sequencer
package lsq_pkg;
    typedef enum logic [1:0] {
        LSQ_IDLE,
        LSQ_ARMED,
        LSQ_DWELL,
        LSQ_WAIT_TRIG
    } lsq_state_type;
endpackage

// ==== hdl/lsq_sequencer.sv ====
// Output list sequencer with Avalon-MM register slave
`timescale 1ns/1ns
`include "lsq_consts.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// (R01) Repeat whole list 1 to 9999 times
// (R02) Endless repeat, read back as 9.9E37 code
// (R03) Abort stops stepping, restores prior setpoints
// (R04) Hold up to 100 clamped current steps
// (R05) Steps run in written order
// (R06) Lists valid at common length or length one
// (R07) Writing a list replaces it entirely
// (R08) Report entry count of each list
// (R09) Dwell 0.01 to 3600 s, millisecond counter
// (R10) Hold each step for its dwell
// (R11) Dwell-paced: one start trigger, then auto advance
// (R12) Trigger-paced: one step per trigger after each dwell, dwell triggers ignored
// (R13) Reset: one minimum step, 0.01 s, count 1
// (R14) Keep-final: last value becomes immediate setpoint
// (R15) Otherwise restore prior setpoints at end
// (R16) Triggers ignored unless armed; rearm per trigger unless cfg_cont set
// (R17) Start and end trigger pulses per step flag
// (R18) Voltage list stepped alongside current list
// (R19) Wrap index, decrement count, finish at the wrap when count is one
module lsq_sequencer #(
    parameter int MS_CYCLES = `LSQ_MS_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        trig_i,
    output logic      [15:0] curr_set_o,
    output logic      [15:0] volt_set_o,
    output logic             step_start_trigger_out_o,
    output logic             step_end_trigger_out_o,
    output logic             running_o
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state per access
    logic        next_wait;
    logic [31:0] next_rdata;
    logic        wr_go;
    logic [31:0] rd_mux;
    logic        in_list;
    logic [2:0]  acc_list;

    always_comb
    begin
        next_wait = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
        next_rdata = avs_readdata_o;
        if (avs_read_i && avs_waitrequest_o)
            next_rdata = rd_mux;
        wr_go = avs_write_i && !avs_waitrequest_o
                && (avs_byteenable_i == 4'hF);
        in_list = (avs_address_i >= `LSQ_A_LIST_BASE)
                  && (avs_address_i <= `LSQ_A_LIST_LAST)
                  && (avs_address_i[1:0] == 2'h0);
        acc_list = 3'(8'(avs_address_i - `LSQ_A_LIST_BASE) >> 3);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end
        else
        begin
            avs_waitrequest_o <= next_wait;
            avs_readdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step lists
    logic [21:0] list_mem [5][100];
    logic [6:0]  list_len [5];
    logic [6:0]  next_len [5];
    logic        mem_we;
    logic [21:0] mem_d;
    logic [6:0]  max_len;
    logic        list_valid;

    function automatic logic [21:0] clamp_val(input logic [2:0] l,
                                              input logic [31:0] d);
        logic [21:0] lo;
        logic [21:0] hi;
        lo = (l == `LSQ_L_DWELL) ? `LSQ_DWELL_MIN : 22'h0;
        hi = (l == `LSQ_L_DWELL) ? `LSQ_DWELL_MAX
           : (l >= `LSQ_L_START) ? 22'h1 : `LSQ_SET_MAX;
        if (d > {10'h0, hi})
            return hi;
        else if (d[21:0] < lo)
            return lo;
        return d[21:0];
    endfunction

    function automatic logic [21:0] elem(input logic [2:0] l,
                                         input logic [6:0] s);
        return list_mem[l][(list_len[l] == 7'd1) ? 7'd0 : s];
    endfunction

    always_comb
    begin
        mem_we = 1'b0;
        mem_d = clamp_val(acc_list, avs_writedata_i);  // [R04]
        max_len = 7'd0;
        for (int i = 0; i < 5; i++)
        begin
            next_len[i] = list_len[i];
            if (list_len[i] > max_len)
                max_len = list_len[i];
        end
        list_valid = (max_len != 7'd0);
        for (int i = 0; i < 5; i++)
            if (list_len[i] != max_len && list_len[i] != 7'd1)
                list_valid = 1'b0;  // [R06]
        if (wr_go && in_list)
        begin
            if (!avs_address_i[2])
                next_len[acc_list] = 7'd0;  // [R07]
            else if (list_len[acc_list] < `LSQ_MAX_STEPS)
            begin
                mem_we = 1'b1;  // [R05]
                next_len[acc_list] = list_len[acc_list] + 7'd1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 5; i++)
            begin
                list_len[i] <= 7'd1;  // [R13]
                for (int j = 0; j < 100; j++)
                    list_mem[i][j] <= (i == 2) ? `LSQ_DWELL_MIN : 22'h0;
            end
        end
        else
        begin
            list_len <= next_len;
            if (mem_we)
                list_mem[acc_list][list_len[acc_list]] <= mem_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and immediate setpoints
    logic        cfg_paced;
    logic        cfg_keep;
    logic        cfg_cont;
    logic        endless;
    logic [13:0] count;
    logic [15:0] imm_curr;
    logic [15:0] imm_volt;
    logic        next_paced;
    logic        next_keep;
    logic        next_cont;
    logic        next_endless;
    logic [13:0] next_count;
    logic [15:0] next_imm_curr;
    logic [15:0] next_imm_volt;
    logic        keep_load;
    logic [6:0]  step;

    always_comb
    begin
        next_paced = cfg_paced;
        next_keep = cfg_keep;
        next_cont = cfg_cont;
        next_endless = endless;
        next_count = count;
        next_imm_curr = imm_curr;
        next_imm_volt = imm_volt;
        if (keep_load)
        begin
            next_imm_curr = 16'(elem(`LSQ_L_CURR, step));  // [R14]
            next_imm_volt = 16'(elem(`LSQ_L_VOLT, step));
        end
        if (wr_go)
            unique case (avs_address_i)
                `LSQ_A_CONFIG:
                begin
                    next_paced = avs_writedata_i[`LSQ_CFG_PACED];
                    next_keep = avs_writedata_i[`LSQ_CFG_KEEP];
                    next_cont = avs_writedata_i[`LSQ_CFG_CONT];
                end
                `LSQ_A_COUNT:
                begin
                    next_endless = avs_writedata_i[`LSQ_COUNT_ENDLESS];
                    if (avs_writedata_i[30:0] > 31'(`LSQ_COUNT_MAX))
                        next_count = `LSQ_COUNT_MAX;  // [R01]
                    else if (avs_writedata_i[13:0] < `LSQ_COUNT_MIN)
                        next_count = `LSQ_COUNT_MIN;
                    else
                        next_count = avs_writedata_i[13:0];
                end
                `LSQ_A_IMM_CURR:
                    next_imm_curr = 16'(clamp_val(`LSQ_L_CURR,
                                                  avs_writedata_i));
                `LSQ_A_IMM_VOLT:
                    next_imm_volt = 16'(clamp_val(`LSQ_L_VOLT,
                                                  avs_writedata_i));
                default:
                    ;
            endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_paced <= 1'b0;  // [R13]
            cfg_keep <= 1'b0;
            cfg_cont <= 1'b0;
            endless <= 1'b0;
            count <= `LSQ_COUNT_MIN;
            imm_curr <= 16'h0;
            imm_volt <= 16'h0;
        end
        else
        begin
            cfg_paced <= next_paced;
            cfg_keep <= next_keep;
            cfg_cont <= next_cont;
            endless <= next_endless;
            count <= next_count;
            imm_curr <= next_imm_curr;
            imm_volt <= next_imm_volt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pin synchroniser and edge
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end
        else
        begin
            trig_s1 <= trig_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    lsq_pkg::lsq_state_type state;
    lsq_pkg::lsq_state_type next_state;
    logic        armed;
    logic        done;
    logic [13:0] remain;
    logic [13:0] presc;
    logic [21:0] dwell_left;
    logic        next_armed;
    logic        next_done;
    logic [13:0] next_remain;
    logic [13:0] next_presc;
    logic [21:0] next_dwell_left;
    logic [6:0]  next_step;
    logic        next_start_out;
    logic        next_end_out;
    logic        trig_ev;
    logic        ctrl_wr;
    logic        advance;
    logic        load;

    always_comb
    begin
        ctrl_wr = wr_go && (avs_address_i == `LSQ_A_CTRL);
        trig_ev = armed && ((trig_s2 && !trig_s3)
                  || (ctrl_wr && avs_writedata_i[`LSQ_CTRL_TRIG]));  // [R16]
        next_state = state;
        next_armed = armed || cfg_cont;
        next_done = done;
        next_remain = remain;
        next_step = step;
        next_presc = (presc == 14'(MS_CYCLES - 1)) ? 14'h0 : presc + 14'h1;
        next_dwell_left = dwell_left;
        next_start_out = 1'b0;
        next_end_out = 1'b0;
        keep_load = 1'b0;
        advance = 1'b0;
        load = 1'b0;
        if (trig_ev && !cfg_cont && state != lsq_pkg::LSQ_DWELL)
            next_armed = 1'b0;
        if (ctrl_wr && avs_writedata_i[`LSQ_CTRL_ARM])
            next_armed = 1'b1;
        unique case (state)
            lsq_pkg::LSQ_IDLE:
                if (ctrl_wr && avs_writedata_i[`LSQ_CTRL_ARM] && list_valid)
                begin
                    next_state = lsq_pkg::LSQ_ARMED;
                    next_done = 1'b0;
                    next_remain = count;
                end
            lsq_pkg::LSQ_ARMED:
                if (trig_ev)
                begin
                    next_step = 7'd0;  // [R11]
                    load = 1'b1;
                end
            lsq_pkg::LSQ_DWELL:
                if (presc == 14'(MS_CYCLES - 1))
                begin
                    next_dwell_left = dwell_left - 22'd1;  // [R09]
                    if (dwell_left == 22'd1)
                    begin
                        next_end_out = 1'(elem(`LSQ_L_END, step));  // [R17]
                        if (cfg_paced)
                            next_state = lsq_pkg::LSQ_WAIT_TRIG;  // [R12]
                        else
                            advance = 1'b1;  // [R11]
                    end
                end
            lsq_pkg::LSQ_WAIT_TRIG:
                advance = trig_ev;  // [R12]
        endcase
        if (advance)
        begin
            if (step == max_len - 7'd1)
            begin
                next_step = 7'd0;  // [R19]
                if (!endless && remain == 14'd1)  // [R02]
                begin
                    next_state = lsq_pkg::LSQ_IDLE;
                    next_done = 1'b1;
                    keep_load = cfg_keep;  // [R14] [R15]
                end
                else
                begin
                    next_remain = endless ? remain : remain - 14'd1;  // [R01]
                    load = 1'b1;
                end
            end
            else
            begin
                next_step = step + 7'd1;  // [R05]
                load = 1'b1;
            end
        end
        if (load)
        begin
            next_state = lsq_pkg::LSQ_DWELL;  // [R10]
            next_presc = 14'h0;
            next_dwell_left = elem(`LSQ_L_DWELL, next_step);
            next_start_out = 1'(elem(`LSQ_L_START, next_step));  // [R17]
        end
        if (ctrl_wr && avs_writedata_i[`LSQ_CTRL_ABORT])
        begin
            next_state = lsq_pkg::LSQ_IDLE;  // [R03]
            next_armed = 1'b0;
            next_start_out = 1'b0;
            next_end_out = 1'b0;
            keep_load = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= lsq_pkg::LSQ_IDLE;
            armed <= 1'b0;
            done <= 1'b0;
            remain <= `LSQ_COUNT_MIN;
            step <= 7'd0;
            presc <= 14'h0;
            dwell_left <= `LSQ_DWELL_MIN;
            step_start_trigger_out_o <= 1'b0;
            step_end_trigger_out_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            armed <= next_armed;
            done <= next_done;
            remain <= next_remain;
            step <= next_step;
            presc <= next_presc;
            dwell_left <= next_dwell_left;
            step_start_trigger_out_o <= next_start_out;
            step_end_trigger_out_o <= next_end_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setpoint outputs and read mux
    logic stepping;

    always_comb
    begin
        stepping = (next_state == lsq_pkg::LSQ_DWELL)
                   || (next_state == lsq_pkg::LSQ_WAIT_TRIG);
        rd_mux = 32'h0;
        if (in_list && !avs_address_i[2])
            rd_mux = {25'h0, list_len[acc_list]};  // [R08]
        else
            unique case (avs_address_i)
                `LSQ_A_CONFIG:
                    rd_mux = {29'h0, cfg_cont, cfg_keep, cfg_paced};
                `LSQ_A_COUNT:
                    rd_mux = endless ? `LSQ_ENDLESS_CODE
                                     : {18'h0, count};  // [R02]
                `LSQ_A_IMM_CURR:
                    rd_mux = {16'h0, imm_curr};
                `LSQ_A_IMM_VOLT:
                    rd_mux = {16'h0, imm_volt};
                `LSQ_A_STATUS:
                    rd_mux = {2'h0, remain, 1'b0, step, 4'h0, done,
                              list_valid, armed,
                              state != lsq_pkg::LSQ_IDLE};
                default:
                    rd_mux = 32'h0;
            endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            curr_set_o <= 16'h0;
            volt_set_o <= 16'h0;
            running_o <= 1'b0;
        end
        else
        begin
            curr_set_o <= stepping ? 16'(elem(`LSQ_L_CURR, next_step))
                                   : next_imm_curr;  // [R03] [R15]
            volt_set_o <= stepping ? 16'(elem(`LSQ_L_VOLT, next_step))
                                   : next_imm_volt;  // [R18]
            running_o <= (next_state != lsq_pkg::LSQ_IDLE);
        end
    end

endmodule

// ==== dv/lsq_trig_src.sv ====
// Trigger source model on the far side of the sequencer
`timescale 1ns/1ns
module lsq_trig_src (
    input  wire logic clk_i,
    input  wire logic fire_i,
    output logic      trig_o
);
    logic [1:0] width_cnt = 2'h0;

    // Pulse wide enough for the two-flop synchroniser
    always @(posedge clk_i)
        if (fire_i)
            width_cnt <= 2'h3;
        else if (width_cnt != 2'h0)
            width_cnt <= width_cnt - 2'h1;
    assign trig_o = (width_cnt != 2'h0);
endmodule

// ==== dv/lsq_sva.sv ====
// Port assertions of the list sequencer
`timescale 1ns/1ns
`include "lsq_consts.svh"
module lsq_sva #(
    parameter int MS_CYCLES = `LSQ_MS_CYCLES
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        trig_i,
    input wire logic [15:0] curr_set_o,
    input wire logic [15:0] volt_set_o,
    input wire logic        step_start_trigger_out_o,
    input wire logic        step_end_trigger_out_o,
    input wire logic        running_o
);
    localparam int MIN_GAP = 10 * MS_CYCLES - 2;
    logic [31:0] since_start;
    logic [31:0] next_since_start;
    logic        abort_wr;

    assign abort_wr = avs_write_i && !avs_waitrequest_o
        && avs_address_i == `LSQ_A_CTRL && avs_byteenable_i == 4'hF
        && avs_writedata_i[`LSQ_CTRL_ABORT];

    always_comb
        next_since_start = step_start_trigger_out_o ? 32'h0
                                                    : since_start + 32'h1;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            since_start <= 32'hFFFF;
        else
            since_start <= next_since_start;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    wait_one_a: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no answer one cycle after request");
    wait_drop_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    wait_idle_a: assert property (!(avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
    reset_val_a: assert property ($fell(rst_i) |-> avs_waitrequest_o
        && !running_o && curr_set_o == 16'h0 && volt_set_o == 16'h0)
        else $error("bad values after reset");
    start_one_a: assert property (step_start_trigger_out_o
        |=> !step_start_trigger_out_o)
        else $error("start pulse too long");
    end_one_a: assert property (step_end_trigger_out_o
        |=> !step_end_trigger_out_o)
        else $error("end pulse too long");
    start_run_a: assert property (step_start_trigger_out_o
        |-> running_o)
        else $error("step start while idle");
    arm_cause_a: assert property ($rose(running_o)
        |-> $past(avs_write_i) && !$past(avs_waitrequest_o))
        else $error("run began without a bus write");
    abort_stop_a: assert property (abort_wr |-> ##[1:2] !running_o)
        else $error("abort did not stop the list");
    dwell_hold_a: assert property (step_end_trigger_out_o
        |-> since_start >= 32'(MIN_GAP))
        else $error("step ended before its dwell");
endmodule

bind lsq_sequencer lsq_sva #(.MS_CYCLES(MS_CYCLES)) sva_i (.clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .trig_i,
    .curr_set_o, .volt_set_o, .step_start_trigger_out_o,
    .step_end_trigger_out_o, .running_o);

// ==== dv/tb_lsq_sequencer.sv ====
// Self-checking bench of the list sequencer
`timescale 1ns/1ns
`include "lsq_consts.svh"
module tb_lsq_sequencer;
    localparam int MS = 10;
    localparam int GAP = 10 * MS;
    logic        clk_i;
    logic        rst_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        trig_i;
    logic        fire;
    logic [15:0] curr_set_o;
    logic [15:0] volt_set_o;
    logic        step_start_trigger_out_o;
    logic        step_end_trigger_out_o;
    logic        running_o;
    logic [3:0]  be;
    logic [31:0] rd;
    int          mismatches;
    int          checks_done;
    int          cycles;
    int          n;

    lsq_sequencer #(.MS_CYCLES(MS)) dut (.clk_i, .rst_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .trig_i, .curr_set_o,
        .volt_set_o, .step_start_trigger_out_o, .step_end_trigger_out_o,
        .running_o);
    lsq_trig_src src (.clk_i(clk_i), .fire_i(fire), .trig_o(trig_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("mismatches=%0d checks=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task setlist(input logic [7:0] a, input int cnt, input logic [31:0] v);
        wr(a, 32'h0);
        for (int i = 1; i <= cnt; i++)
            wr(a + 8'h04, v * i);
    endtask

    task wp(input logic e);
        n = 1;
        @(posedge clk_i);
        while ((e ? step_end_trigger_out_o : step_start_trigger_out_o)
               !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task wi;
        n = 0;
        while (running_o !== 1'b0)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
    endtask

    task pulse_trig;
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk({16'h0, curr_set_o}, 32'h0);
        chk({16'h0, volt_set_o}, 32'h0);
        rc(`LSQ_A_COUNT, 32'h1);
        rc(`LSQ_A_CONFIG, 32'h0);
        rc(8'h18, 32'h1);
        rc(8'h28, 32'h1);
    endtask

    task t_regs;
        wr(`LSQ_A_COUNT, 32'h0);
        rc(`LSQ_A_COUNT, 32'h1);
        wr(`LSQ_A_COUNT, 32'h270F);
        rc(`LSQ_A_COUNT, 32'h270F);
        wr(`LSQ_A_COUNT, 32'h2710);
        rc(`LSQ_A_COUNT, 32'h270F);
        wr(`LSQ_A_COUNT, 32'h80000000);
        rc(`LSQ_A_COUNT, `LSQ_ENDLESS_CODE);
        be = 4'h3;
        wr(`LSQ_A_COUNT, 32'h2);
        be = 4'hF;
        rc(`LSQ_A_COUNT, `LSQ_ENDLESS_CODE);
        wr(`LSQ_A_IMM_CURR, 32'hFFFF);
        rc(`LSQ_A_IMM_CURR, 32'hC350);
        wr(`LSQ_A_IMM_CURR, 32'h55);
        rc(`LSQ_A_IMM_CURR, 32'h55);
        wr(`LSQ_A_IMM_VOLT, 32'h1234);
        rc(`LSQ_A_IMM_VOLT, 32'h1234);
        rc(8'hFC, 32'h0);
        rc(`LSQ_A_CTRL, 32'h0);
    endtask

    task t_unarmed;
        pulse_trig;
        repeat (10) @(posedge clk_i);
        chk({31'h0, running_o}, 32'h0);
    endtask

    task t_lists;
        setlist(8'h18, 3, 32'h64);
        rc(8'h18, 32'h3);
        setlist(8'h18, 2, 32'h64);
        rc(8'h18, 32'h2);
        setlist(8'h18, 3, 32'h64);
        setlist(8'h28, 2, 32'h3);
        rc(8'h28, 32'h2);
        xfer(1'b0, `LSQ_A_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h0);
        wr(`LSQ_A_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        chk({31'h0, running_o}, 32'h0);
        setlist(8'h28, 1, 32'h3);
        setlist(8'h20, 1, 32'h7);
        setlist(8'h30, 1, 32'h1);
        setlist(8'h38, 1, 32'h1);
        xfer(1'b0, `LSQ_A_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
    endtask

    task t_auto;
        wr(`LSQ_A_COUNT, 32'h2);
        wr(`LSQ_A_CONFIG, 32'h0);
        wr(`LSQ_A_CTRL, 32'h1);
        pulse_trig;
        for (int s = 0; s < 6; s++)
        begin
            wp(1'b0);
            chk({16'h0, curr_set_o}, 32'h64 * (s % 3 + 1));
            chk({16'h0, volt_set_o}, 32'h7);
            if (s > 0)
                chk(32'(n), 32'(GAP));
        end
        wi;
        chk({16'h0, curr_set_o}, 32'h55);
        chk({16'h0, volt_set_o}, 32'h1234);
        xfer(1'b0, `LSQ_A_STATUS, 32'h0);
        chk({31'h0, rd[3]}, 32'h1);
    endtask

    task t_keep;
        wr(`LSQ_A_CONFIG, 32'h2);
        wr(`LSQ_A_COUNT, 32'h1);
        wr(`LSQ_A_CTRL, 32'h1);
        wr(`LSQ_A_CTRL, 32'h4);
        repeat (3) wp(1'b0);
        wi;
        chk({16'h0, curr_set_o}, 32'h12C);
        rc(`LSQ_A_IMM_CURR, 32'h12C);
    endtask

    task t_paced;
        wr(`LSQ_A_CONFIG, 32'h5);
        wr(`LSQ_A_CTRL, 32'h1);
        pulse_trig;
        wp(1'b0);
        chk({16'h0, curr_set_o}, 32'h64);
        wr(`LSQ_A_CTRL, 32'h4);
        wp(1'b1);
        repeat (20) @(posedge clk_i);
        chk({16'h0, curr_set_o}, 32'h64);
        wr(`LSQ_A_CTRL, 32'h4);
        wp(1'b0);
        chk({16'h0, curr_set_o}, 32'hC8);
        wr(`LSQ_A_CTRL, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({31'h0, running_o}, 32'h0);
        chk({16'h0, curr_set_o}, 32'h12C);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict;
        end
    end

    initial
    begin
        rst_i = 1'b1;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'hF;
        be = 4'hF;
        fire = 1'b0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_regs;
        t_unarmed;
        t_lists;
        t_auto;
        t_keep;
        t_paced;
        print_verdict;
    end
endmodule
